// file: pkg/countdown_timer_pkg.sv
package countdown_timer_pkg;

  // memory bus window, counted in 16-bit words
  localparam int          ADDR_W        = 22;
  localparam logic [21:0] WINDOW_BASE   = 22'h00_0C00;
  localparam logic [21:0] WINDOW_LAST   = 22'h00_0C3F;
  localparam int          WINDOW_WORDS  = 64;
  localparam int          WORD_IDX_W    = 6;

  // per-timer block of eight words
  localparam int          TIMER_COUNT   = 3;
  localparam int          TIMER_STRIDE  = 8;
  localparam logic [2:0]  OFS_COUNT_LO  = 3'h0;
  localparam logic [2:0]  OFS_COUNT_HI  = 3'h1;
  localparam logic [2:0]  OFS_PERIOD_LO = 3'h2;
  localparam logic [2:0]  OFS_PERIOD_HI = 3'h3;
  localparam logic [2:0]  OFS_CONTROL   = 3'h4;
  localparam logic [2:0]  OFS_PRESCALE  = 3'h6;

  // control word fields
  localparam int          CTL_STOP_BIT   = 0;
  localparam int          CTL_RELOAD_BIT = 1;
  localparam int          CTL_IEN_BIT    = 2;
  localparam int          CTL_FLAG_BIT   = 3;

  // widths and reset values
  localparam int          COUNT_W         = 32;
  localparam int          PRESCALE_W      = 16;
  localparam logic [31:0] PERIOD_RESET    = 32'hFFFF_FFFF;
  localparam logic [15:0] PRESCALE_RESET  = 16'h0000;

  // one access from the cpu memory bus
  typedef struct packed {
    logic [21:0] addr;
    logic        wr;
    logic        rd;
    logic        wide;
    logic [31:0] wdata;
  } mem_req_type;

  // interrupt lines leaving the block
  typedef struct packed {
    logic expander;
    logic line_thirteen;
    logic line_fourteen;
  } timer_irq_type;

endpackage

// file: design/countdown_timers.sv
// Behaviour
// [RULE_01] three identical timers, each a 32-bit down counter with presettable period
// [RULE_02] each timer has a 16-bit prescaler dividing the cpu clock
// [RULE_03] interrupt raised whenever the down counter reaches zero
// [RULE_04] counter decrements once per prescaled clock period
// [RULE_05] at zero the counter reloads from its period and keeps counting
// [RULE_06] timer 2 drives cpu interrupt line fourteen directly
// [RULE_07] timer 1 may be routed to cpu interrupt line thirteen
// [RULE_08] timer 0 goes to the peripheral interrupt expander
// [RULE_09] registers decode in a 64-word window, no protected-write enable needed
// [RULE_10] window accepts 16-bit and 32-bit reads and writes
// [RULE_11] window sits directly on the cpu memory bus as plain memory
// [RULE_12] prescaler sub-counter reloads on expiry, one decrement enable each time
// [RULE_13] zero event held as a flag software clears, once per reload cycle
`timescale 1ns/100ps
module countdown_timers #(
  parameter int NUM_TIMERS = countdown_timer_pkg::TIMER_COUNT
) (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               nrst,
  // cpu memory bus
  input  wire countdown_timer_pkg::mem_req_type   mem_req,
  output logic                                    mem_hit,
  output logic [31:0]                             mem_rdata,
  output logic                                    mem_rvalid,
  // interrupt routing and outputs
  input  wire logic                               route_t1_to_line13,
  output countdown_timer_pkg::timer_irq_type      irq
);

  // local short names for the counter and prescaler widths
  localparam int CW = countdown_timer_pkg::COUNT_W;
  localparam int PW = countdown_timer_pkg::PRESCALE_W;

  // word image of the window, unused words read as zero
  logic [15:0] word_img [countdown_timer_pkg::WINDOW_WORDS];
  logic [NUM_TIMERS-1:0] irq_level;

  // window decode: no protection gate, plain memory on the cpu bus
  logic                  in_window;
  logic [5:0]            widx;
  logic [5:0]            widx_even;
  assign in_window = (mem_req.addr >= countdown_timer_pkg::WINDOW_BASE) &&
                     (mem_req.addr <= countdown_timer_pkg::WINDOW_LAST); // RULE_09 RULE_11
  // a hit needs a strobe as well as an address inside the window
  assign mem_hit   = in_window && (mem_req.wr || mem_req.rd);
  // word index inside the window; a wide access always starts on the even word
  assign widx      = mem_req.addr[5:0];
  assign widx_even = {mem_req.addr[5:1], 1'b0};

  // true when the current write covers word w
  function automatic logic word_wr(input logic [5:0] w);
    logic hit;
    hit = 1'b0;
    if (in_window && mem_req.wr) begin
      if (mem_req.wide) begin
        hit = (w[5:1] == widx_even[5:1]); // RULE_10
      end else begin
        hit = (w == widx);
      end
    end
    return hit;
  endfunction

  // data lane feeding word w of the current write
  function automatic logic [15:0] word_data(input logic [5:0] w);
    logic [15:0] d;
    d = mem_req.wdata[15:0];
    if (mem_req.wide && w[0]) begin
      d = mem_req.wdata[31:16]; // RULE_10
    end
    return d;
  endfunction

  // one block of eight words per timer
  genvar t;
  generate
    for (t = 0; t < NUM_TIMERS; t++) begin : g_timer // RULE_01
      localparam logic [5:0] BASE = 6'(t * countdown_timer_pkg::TIMER_STRIDE);
      localparam logic [5:0] A_CLO = BASE + 6'(countdown_timer_pkg::OFS_COUNT_LO);
      localparam logic [5:0] A_CHI = BASE + 6'(countdown_timer_pkg::OFS_COUNT_HI);
      localparam logic [5:0] A_PLO = BASE + 6'(countdown_timer_pkg::OFS_PERIOD_LO);
      localparam logic [5:0] A_PHI = BASE + 6'(countdown_timer_pkg::OFS_PERIOD_HI);
      localparam logic [5:0] A_CTL = BASE + 6'(countdown_timer_pkg::OFS_CONTROL);
      localparam logic [5:0] A_PSC = BASE + 6'(countdown_timer_pkg::OFS_PRESCALE);

      // per-timer state and strobes
      logic [CW-1:0] count_reg;
      logic [CW-1:0] period_reg;
      logic [PW-1:0] prescale_reg;
      logic [PW-1:0] sub_reg;
      logic          stop_reg;
      logic          ien_reg;
      logic          flag_reg;
      logic          tick;
      logic          zero_event;
      logic          reload_req;
      logic [15:0]   ctl_wdata;
      logic [PW-1:0] sub_start;

      // control write strobes; always_comb also wakes on the bus reads inside the helpers
      always_comb begin
        ctl_wdata  = word_data(A_CTL);
        reload_req = word_wr(A_CTL) && ctl_wdata[countdown_timer_pkg::CTL_RELOAD_BIT];
      end
      // a setting of zero divides by one, otherwise by the setting itself
      assign sub_start  = (prescale_reg == '0) ? '0 : prescale_reg - 1'b1; // RULE_04
      assign tick       = !stop_reg && (sub_reg == '0); // RULE_12
      assign zero_event = tick && (count_reg == '0); // RULE_03

      // period and prescale settings
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          period_reg   <= countdown_timer_pkg::PERIOD_RESET;
          prescale_reg <= countdown_timer_pkg::PRESCALE_RESET;
        end else begin
          if (word_wr(A_PLO)) begin
            period_reg[15:0] <= word_data(A_PLO);
          end
          if (word_wr(A_PHI)) begin
            period_reg[31:16] <= word_data(A_PHI);
          end
          if (word_wr(A_PSC)) begin
            prescale_reg <= word_data(A_PSC); // RULE_02
          end
        end
      end

      // prescaler sub-counter
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sub_reg <= countdown_timer_pkg::PRESCALE_RESET;
        end else if (reload_req || tick) begin
          sub_reg <= sub_start; // RULE_12
        end else if (!stop_reg) begin
          sub_reg <= sub_reg - 1'b1;
        end
      end

      // main down counter with automatic reload
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          count_reg <= countdown_timer_pkg::PERIOD_RESET;
        end else if (reload_req) begin
          count_reg <= period_reg;
        end else if (zero_event) begin
          count_reg <= period_reg; // RULE_05
        end else if (tick) begin
          count_reg <= count_reg - 1'b1; // RULE_04
        end
      end

      // control bits; a zero event beats a same-cycle clear
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          stop_reg <= 1'b0;
          ien_reg  <= 1'b0;
          flag_reg <= 1'b0;
        end else begin
          if (word_wr(A_CTL)) begin
            stop_reg <= ctl_wdata[countdown_timer_pkg::CTL_STOP_BIT];
            ien_reg  <= ctl_wdata[countdown_timer_pkg::CTL_IEN_BIT];
          end
          if (zero_event) begin
            flag_reg <= 1'b1; // RULE_13
          end else if (word_wr(A_CTL) && ctl_wdata[countdown_timer_pkg::CTL_FLAG_BIT]) begin
            flag_reg <= 1'b0;
          end
        end
      end

      // level towards the interrupt lines, held until software clears flag or enable
      assign irq_level[t] = flag_reg && ien_reg; // RULE_03

      // register image of this timer; one driver per word, spare words read zero
      assign word_img[A_CLO]        = count_reg[15:0];
      assign word_img[A_CHI]        = count_reg[31:16];
      assign word_img[A_PLO]        = period_reg[15:0];
      assign word_img[A_PHI]        = period_reg[31:16];
      assign word_img[A_CTL]        = {12'h000, flag_reg, ien_reg, 1'b0, stop_reg};
      assign word_img[A_CTL + 6'd1] = 16'h0000;
      assign word_img[A_PSC]        = prescale_reg;
      assign word_img[A_PSC + 6'd1] = 16'h0000;
    end

    // words beyond the last timer read as zero
    for (t = NUM_TIMERS * countdown_timer_pkg::TIMER_STRIDE;
         t < countdown_timer_pkg::WINDOW_WORDS; t++) begin : g_unused
      assign word_img[t] = 16'h0000;
    end
  endgenerate

  // read answer strobe, a one-cycle pulse after each read in the window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= in_window && mem_req.rd; // RULE_11
    end
  end

  // read data, one cycle after the request, held until the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_rdata <= 32'h0000_0000;
    end else begin
      if (in_window && mem_req.rd) begin
        if (mem_req.wide) begin
          mem_rdata <= {word_img[widx_even + 6'd1], word_img[widx_even]}; // RULE_10
        end else begin
          mem_rdata <= {16'h0000, word_img[widx]};
        end
      end
    end
  end

  // interrupt routing
  assign irq.expander      = irq_level[0]; // RULE_08
  assign irq.line_thirteen = irq_level[1] && route_t1_to_line13; // RULE_07
  assign irq.line_fourteen = irq_level[2]; // RULE_06

endmodule

// file: tb/countdown_timers_assertions.sv
`timescale 1ns/100ps
module countdown_timers_checker (
  // clock and reset
  input wire logic                               clk,
  input wire logic                               nrst,
  // bus and interrupt ports
  input wire countdown_timer_pkg::mem_req_type   mem_req,
  input wire logic                               mem_hit,
  input wire logic [31:0]                        mem_rdata,
  input wire logic                               mem_rvalid,
  input wire logic                               route_t1_to_line13,
  input wire countdown_timer_pkg::timer_irq_type irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a read taken in the window, and its answer one cycle on
  sequence s_take; mem_req.rd && mem_hit; endsequence
  sequence s_ans; mem_rvalid; endsequence
  property p_hit; mem_hit == ((mem_req.rd || mem_req.wr)
    && mem_req.addr >= countdown_timer_pkg::WINDOW_BASE
    && mem_req.addr <= countdown_timer_pkg::WINDOW_LAST); endproperty
  property p_ans; s_take |=> s_ans; endproperty
  property p_quiet; !(mem_req.rd && mem_hit) |=> !mem_rvalid; endproperty
  property p_narrow; s_take ##0 !mem_req.wide |=> mem_rdata[31:16] == 16'h0000; endproperty
  property p_unused; s_take ##0 (mem_req.addr[2] && mem_req.addr[0] && !mem_req.wide)
    |=> mem_rdata == 32'h0000_0000; endproperty
  property p_r13; !route_t1_to_line13 |-> !irq.line_thirteen; endproperty
  property p_hold14; irq.line_fourteen && !mem_req.wr |=> irq.line_fourteen; endproperty
  property p_hold0; irq.expander && !mem_req.wr |=> irq.expander; endproperty
  a_hit: assert property (p_hit) else $error("window decode wrong");
  a_ans: assert property (p_ans) else $error("read not answered");
  a_quiet: assert property (p_quiet) else $error("answer without read");
  a_narrow: assert property (p_narrow) else $error("narrow read upper half set");
  a_unused: assert property (p_unused) else $error("unused word not zero");
  a_r13: assert property (p_r13) else $error("line thirteen not routed off");
  a_hold14: assert property (p_hold14) else $error("line fourteen dropped");
  a_hold0: assert property (p_hold0) else $error("expander line dropped");
endmodule

bind countdown_timers countdown_timers_checker u_countdown_timers_checker (
  .clk(clk), .nrst(nrst), .mem_req(mem_req), .mem_hit(mem_hit), .mem_rdata(mem_rdata),
  .mem_rvalid(mem_rvalid), .route_t1_to_line13(route_t1_to_line13), .irq(irq));

// file: tb/irq_sink.sv
`timescale 1ns/100ps
module irq_sink (
  // clock and reset
  input wire logic                               clk,
  input wire logic                               nrst,
  // timer interrupt lines
  input wire countdown_timer_pkg::timer_irq_type irq,
  // cycles between the last two rising edges, per timer
  output logic [31:0]                            gap [3]
);
  logic [31:0] cyc_reg;
  logic [31:0] last_reg [3];
  logic [2:0]  prev_reg;
  // time-stamp rising edges as the interrupt controller latches them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cyc_reg <= '0;
      prev_reg <= '0;
      gap <= '{default: '0};
      last_reg <= '{default: '0};
    end else begin
      cyc_reg <= cyc_reg + 32'h0000_0001;
      prev_reg <= irq;
      for (int i = 0; i < 3; i++) begin
        if (irq[2-i] && !prev_reg[2-i]) begin
          gap[i] <= cyc_reg - last_reg[i];
          last_reg[i] <= cyc_reg;
        end
      end
    end
  end
endmodule

// file: tb/tb_countdown_timers.sv
`timescale 1ns/100ps
module tb_countdown_timers;
  logic clk, nrst, route_t1_to_line13, mem_hit, mem_rvalid, h, rv;
  countdown_timer_pkg::mem_req_type   mem_req;
  countdown_timer_pkg::timer_irq_type irq;
  logic [31:0] mem_rdata, q, d;
  logic [31:0] gap [3];
  logic [21:0] wa [3] = '{22'h00_0C40, 22'h00_0BFF, 22'h00_0C3F};
  int          miscompares, n_compared, dv, per;

  countdown_timers u_countdown_timers (.clk(clk), .nrst(nrst), .mem_req(mem_req),
    .mem_hit(mem_hit), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .route_t1_to_line13(route_t1_to_line13), .irq(irq));
  irq_sink u_irq_sink (.clk(clk), .nrst(nrst), .irq(irq), .gap(gap));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [21:0] ad(input int t, input int o);
    return countdown_timer_pkg::WINDOW_BASE + 22'(8 * t + o);
  endfunction

  // zero-to-zero spacing: period plus one counts, each one prescale long, zero meaning one
  function automatic logic [31:0] exp_gap(input int p, input int s);
    return 32'((p + 1) * ((s == 0) ? 1 : s));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one bus access held for one edge, answer sampled after the next
  task automatic acc(input logic [21:0] a, input logic w, input logic wd, input logic [31:0] wdat);
    @(posedge clk);
    mem_req <= '{addr: a, wr: w, rd: !w, wide: wd, wdata: wdat};
    @(posedge clk);
    h = mem_hit;
    mem_req.wr <= 1'b0;
    mem_req.rd <= 1'b0;
    #1;
    q = mem_rdata;
    rv = mem_rvalid;
  endtask

  // bounded wait for one timer's line to reach level v
  task automatic wait_irq(input int t, input logic v);
    for (int n = 0; n < 400 && irq[2-t] !== v; n++) begin
      @(posedge clk);
      #1;
    end
    chk({31'h0000_0000, irq[2-t]}, {31'h0000_0000, v});
  endtask

  // watchdog
  initial begin
    #400000;
    miscompares++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    route_t1_to_line13 = 1'b0;
    mem_req = '0;
    void'($urandom(78158));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      d = $urandom;
      acc(ad(t, 2), 0, 1, 0); chk(q, 32'hFFFF_FFFF);
      acc(ad(t, 6), 0, 0, 0); chk(q, 32'h0000_0000);
      acc(ad(t, 3), 1, 1, d);
      acc(ad(t, 2), 0, 0, 0); chk(q, {16'h0000, d[15:0]});
      acc(ad(t, 3), 0, 0, 0); chk(q, {16'h0000, d[31:16]});
      acc(ad(t, 2), 0, 1, 0); chk(q, d);
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      acc(wa[i], 0, 0, 0); chk({30'h0000_0000, h, rv}, {30'h0000_0000, i == 2, i == 2});
    end
    acc(ad(0, 5), 0, 0, 0); chk(q, 32'h0000_0000);
    $display("test window done");
    @(posedge clk);
    route_t1_to_line13 <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      dv = (t == 0) ? 1 : 1 + $urandom % 3;
      per = 2 + $urandom % 4;
      acc(ad(t, 6), 1, 0, (t == 0) ? 0 : dv);
      acc(ad(t, 2), 1, 1, per);
      acc(ad(t, 4), 1, 0, 32'h0000_0006);
      repeat (2) begin
        wait_irq(t, 1'b1);
        acc(ad(t, 4), 1, 0, 32'h0000_000C);
        wait_irq(t, 1'b0);
      end
      chk(gap[t], exp_gap(per, (t == 0) ? 0 : dv));
      if (t == 1) begin
        wait_irq(t, 1'b1);
        @(posedge clk);
        route_t1_to_line13 <= 1'b0;
        @(posedge clk);
        #1;
        chk({31'h0000_0000, irq[1]}, 32'h0000_0000);
      end
      acc(ad(t, 4), 1, 0, 32'h0000_0009);
      chk({31'h0000_0000, irq[2-t]}, 32'h0000_0000);
    end
    $display("test timers done");
    close_out();
  end
endmodule
